// *** hw/pif_top.sv ***
// Peripheral interrupt enable and request flag bank
//
// Added by the designer: the plain strobed port and the address map.
`default_nettype none
module pif_top (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  // Register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Peripheral event pulses, one bit per flag position
  input  wire logic [7:0] flags1_set_i,
  input  wire logic [7:0] flags2_set_i,
  input  wire logic [7:0] flags3_set_i,
  input  wire logic [7:0] flags4_set_i,
  // Serial unit clears its own flags, bit 1 receive, bit 0 transmit
  input  wire logic [1:0] serial_flag_clr_i,
  // Enables held outside this bank
  input  wire logic [7:0] enable1_i,
  input  wire logic [7:0] enable2_i,
  input  wire logic [7:0] enable3_i,
  // Gates from the top interrupt control
  input  wire logic       global_irq_gate_i,
  input  wire logic       peripheral_irq_gate_i,
  // Requests
  output logic            periph_request_o,
  output logic            wake_request_o,
  output logic            irq_o
);
  pif_pkg::pif_byte_type enable4;
  pif_pkg::pif_byte_type flags1;
  pif_pkg::pif_byte_type flags2;
  pif_pkg::pif_byte_type flags3;
  pif_pkg::pif_byte_type flags4;
  pif_pkg::pif_byte_type mask_q;
  pif_pkg::pif_byte_type status_q;
  pif_pkg::pif_byte_type status_set;
  pif_pkg::pif_byte_type rdata_q;
  pif_pkg::pif_byte_type rdata_d;
  pif_pkg::pif_byte_type flags1_hw_clr;
  logic                  wr_enable4;
  logic                  wr_flags1;
  logic                  wr_flags2;
  logic                  wr_flags3;
  logic                  wr_flags4;
  logic                  wr_status;
  logic                  wr_mask;
  logic                  any_pending;
  logic                  periph_request_q;
  logic                  wake_request_q;

  // Write decode
  assign wr_enable4 = wr_i && (addr_i == pif_pkg::OFS_ENABLE_4);
  assign wr_flags1  = wr_i && (addr_i == pif_pkg::OFS_FLAGS_1);
  assign wr_flags2  = wr_i && (addr_i == pif_pkg::OFS_FLAGS_2);
  assign wr_flags3  = wr_i && (addr_i == pif_pkg::OFS_FLAGS_3);
  assign wr_flags4  = wr_i && (addr_i == pif_pkg::OFS_FLAGS_4);
  assign wr_status  = wr_i && (addr_i == pif_pkg::OFS_STATUS);
  assign wr_mask    = wr_i && (addr_i == pif_pkg::OFS_MASK);

  // Serial flags follow the serial unit, software cannot touch them
  always_comb
  begin
    flags1_hw_clr = 8'h00;
    flags1_hw_clr[pif_pkg::BIT_SERIAL_RECEIVE_FLAG]  = serial_flag_clr_i[1];
    flags1_hw_clr[pif_pkg::BIT_SERIAL_TRANSMIT_FLAG] = serial_flag_clr_i[0];
  end

  pif_enable_reg #(
    .IMPL (pif_pkg::IMPL_ENABLE_4)
  ) u_enable4 (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .wr_i     (wr_enable4),
    .wdata_i  (wdata_i),
    .value_o  (enable4)
  );

  pif_flag_reg #(
    .IMPL  (pif_pkg::IMPL_FLAGS_1),
    .SW_WR (pif_pkg::WR_FLAGS_1)
  ) u_flags1 (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .wr_i     (wr_flags1),
    .wdata_i  (wdata_i),
    .set_i    (flags1_set_i),
    .hw_clr_i (flags1_hw_clr),
    .flags_o  (flags1)
  );

  pif_flag_reg #(
    .IMPL  (pif_pkg::IMPL_FLAGS_2),
    .SW_WR (pif_pkg::IMPL_FLAGS_2)
  ) u_flags2 (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .wr_i     (wr_flags2),
    .wdata_i  (wdata_i),
    .set_i    (flags2_set_i),
    .hw_clr_i (8'h00),
    .flags_o  (flags2)
  );

  pif_flag_reg #(
    .IMPL  (pif_pkg::IMPL_FLAGS_3),
    .SW_WR (pif_pkg::IMPL_FLAGS_3)
  ) u_flags3 (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .wr_i     (wr_flags3),
    .wdata_i  (wdata_i),
    .set_i    (flags3_set_i),
    .hw_clr_i (8'h00),
    .flags_o  (flags3)
  );

  pif_flag_reg #(
    .IMPL  (pif_pkg::IMPL_FLAGS_4),
    .SW_WR (pif_pkg::IMPL_FLAGS_4)
  ) u_flags4 (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .wr_i     (wr_flags4),
    .wdata_i  (wdata_i),
    .set_i    (flags4_set_i),
    .hw_clr_i (8'h00),
    .flags_o  (flags4)
  );

  // Pending means flag and its enable together
  assign any_pending = |(flags1 & enable1_i) | |(flags2 & enable2_i) |
                       |(flags3 & enable3_i) | |(flags4 & enable4);

  // Registered request; the gates can only mask, never latch
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      periph_request_q <= 1'b0;
      wake_request_q   <= 1'b0;
    end
    else
    begin
      periph_request_q <= any_pending && peripheral_irq_gate_i && global_irq_gate_i;
      // Wake does not need the global gate
      wake_request_q   <= any_pending && peripheral_irq_gate_i;
    end
  end

  // Event status sources
  always_comb
  begin
    status_set = 8'h00;
    status_set[pif_pkg::BIT_EVT_REQUEST_RISE] = any_pending && peripheral_irq_gate_i &&
                                                 global_irq_gate_i && !periph_request_q;
    status_set[pif_pkg::BIT_EVT_READ_ONLY_WRITE] =
      wr_flags1 && (|(wdata_i & ~pif_pkg::WR_FLAGS_1));
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      status_q <= pif_pkg::RST_VALUE;
    end
    else
    begin
      status_q <= ((status_q & ~(wr_status ? wdata_i : 8'h00)) | status_set) &
                  pif_pkg::IMPL_STATUS;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mask_q <= pif_pkg::RST_VALUE;
    end
    else if (wr_mask)
    begin
      mask_q <= wdata_i & pif_pkg::IMPL_STATUS;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (!rd_i)
    begin
      rdata_d = 8'h00;
    end
    else if (addr_i == pif_pkg::OFS_ENABLE_4)
    begin
      rdata_d = enable4;
    end
    else if (addr_i == pif_pkg::OFS_FLAGS_1)
    begin
      rdata_d = flags1;
    end
    else if (addr_i == pif_pkg::OFS_FLAGS_2)
    begin
      rdata_d = flags2;
    end
    else if (addr_i == pif_pkg::OFS_FLAGS_3)
    begin
      rdata_d = flags3;
    end
    else if (addr_i == pif_pkg::OFS_FLAGS_4)
    begin
      rdata_d = flags4;
    end
    else if (addr_i == pif_pkg::OFS_STATUS)
    begin
      rdata_d = status_q;
    end
    else if (addr_i == pif_pkg::OFS_MASK)
    begin
      rdata_d = mask_q;
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_q <= pif_pkg::RST_VALUE;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o          = rdata_q;
  assign periph_request_o = periph_request_q;
  assign wake_request_o   = wake_request_q;
  assign irq_o            = |(status_q & mask_q);

  chk_flag_set: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    flags1_set_i[pif_pkg::BIT_TIMER1_OVERFLOW_FLAG] |=>
      flags1[pif_pkg::BIT_TIMER1_OVERFLOW_FLAG])
    else $error("event pulse did not set its flag");

  chk_gate_blocks: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    !peripheral_irq_gate_i |=> !periph_request_o)
    else $error("request passed with peripheral gate clear");

  chk_enable4_read: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    rd_i && addr_i == pif_pkg::OFS_ENABLE_4 |=> rdata_o[7:2] == 6'h00 &&
      rdata_o[1:0] == $past(enable4[1:0]))
    else $error("enable register 4 read wrong");

  chk_serial_ro: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    wr_flags1 && flags1_set_i[5:4] == 2'b00 && serial_flag_clr_i == 2'b00 |=>
      flags1[5:4] == $past(flags1[5:4]))
    else $error("read-only serial flag changed by software");

  chk_flags2_unimpl: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    flags2_set_i[2:1] == 2'b11 |=> flags2[2:1] == 2'b00)
    else $error("unimplemented flag 2 bits set");

  chk_flags3_unimpl: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    wr_flags3 && wdata_i == 8'hff |=> (flags3 & ~pif_pkg::IMPL_FLAGS_3) == 8'h00 &&
      flags3 == pif_pkg::IMPL_FLAGS_3)
    else $error("flag 3 write wrong");

  chk_flag_read: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    rd_i && addr_i == pif_pkg::OFS_FLAGS_1 |=> rdata_o == $past(flags1) ##1 rdata_o == 8'h00
      || $past(rd_i))
    else $error("flag read returned wrong data");

  chk_port2_clear: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    wr_flags4 && wdata_i == 8'h00 && flags4_set_i[1:0] == 2'b00 |=> flags4 == 8'h00)
    else $error("port 2 flags not cleared by writing zero");

  chk_request_any: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (flags4 & enable4) != 8'h00 && peripheral_irq_gate_i && global_irq_gate_i |=>
      periph_request_o)
    else $error("pending enabled flag raised no request");
endmodule
`default_nettype wire

// *** hw/pif_pkg.sv ***
// Constants, offsets and bit layouts of the peripheral interrupt flag bank
`default_nettype none
package pif_pkg;
  typedef logic [7:0] pif_byte_type;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFS_ENABLE_4 = 4'h0;
  localparam logic [3:0] OFS_FLAGS_1  = 4'h1;
  localparam logic [3:0] OFS_FLAGS_2  = 4'h2;
  localparam logic [3:0] OFS_FLAGS_3  = 4'h3;
  localparam logic [3:0] OFS_FLAGS_4  = 4'h4;
  localparam logic [3:0] OFS_STATUS   = 4'h5;
  localparam logic [3:0] OFS_MASK     = 4'h6;

  // Reset value of every implemented bit
  localparam logic [7:0] RST_VALUE = 8'h00;

  // Implemented and software-writable bit masks
  localparam logic [7:0] IMPL_ENABLE_4 = 8'h03;
  localparam logic [7:0] IMPL_FLAGS_1  = 8'hff;
  localparam logic [7:0] WR_FLAGS_1    = 8'hcf;
  localparam logic [7:0] IMPL_FLAGS_2  = 8'hf9;
  localparam logic [7:0] IMPL_FLAGS_3  = 8'h3a;
  localparam logic [7:0] IMPL_FLAGS_4  = 8'h03;
  localparam logic [7:0] IMPL_STATUS   = 8'h03;

  // Enable register 4 fields
  localparam int unsigned BIT_PORT2_COLLISION_ENABLE = 1;
  localparam int unsigned BIT_PORT2_SERIAL_ENABLE    = 0;

  // Flag register 1 fields
  localparam int unsigned BIT_TIMER1_GATE_FLAG      = 7;
  localparam int unsigned BIT_CONVERTER_DONE_FLAG   = 6;
  localparam int unsigned BIT_SERIAL_RECEIVE_FLAG   = 5;
  localparam int unsigned BIT_SERIAL_TRANSMIT_FLAG  = 4;
  localparam int unsigned BIT_PORT1_SERIAL_FLAG     = 3;
  localparam int unsigned BIT_CAPCOMP1_FLAG         = 2;
  localparam int unsigned BIT_TIMER2_MATCH_FLAG     = 1;
  localparam int unsigned BIT_TIMER1_OVERFLOW_FLAG  = 0;

  // Flag register 2 fields
  localparam int unsigned BIT_OSC_FAIL_FLAG         = 7;
  localparam int unsigned BIT_COMPARATOR2_FLAG      = 6;
  localparam int unsigned BIT_COMPARATOR1_FLAG      = 5;
  localparam int unsigned BIT_NV_WRITE_DONE_FLAG    = 4;
  localparam int unsigned BIT_PORT1_COLLISION_FLAG  = 3;
  localparam int unsigned BIT_CAPCOMP2_FLAG         = 0;

  // Flag register 3 fields
  localparam int unsigned BIT_CAPCOMP4_FLAG         = 5;
  localparam int unsigned BIT_CAPCOMP3_FLAG         = 4;
  localparam int unsigned BIT_TIMER6_MATCH_FLAG     = 3;
  localparam int unsigned BIT_TIMER4_MATCH_FLAG     = 1;

  // Flag register 4 fields
  localparam int unsigned BIT_PORT2_COLLISION_FLAG  = 1;
  localparam int unsigned BIT_PORT2_SERIAL_FLAG     = 0;

  // Event status and mask fields
  localparam int unsigned BIT_EVT_REQUEST_RISE      = 0;
  localparam int unsigned BIT_EVT_READ_ONLY_WRITE   = 1;
endpackage
`default_nettype wire

// *** hw/pif_enable_reg.sv ***
// Software enable register with unimplemented bits held at zero
`default_nettype none
module pif_enable_reg #(
  parameter logic [7:0] IMPL = 8'hff
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  // Write port
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  // Stored value
  output logic      [7:0] value_o
);
  logic [7:0] value_q;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      value_q <= pif_pkg::RST_VALUE;
    end
    else if (wr_i)
    begin
      value_q <= wdata_i & IMPL;
    end
  end

  assign value_o = value_q;
endmodule
`default_nettype wire

// *** hw/pif_flag_reg.sv ***
// Request flag register: hardware sets, software writes, set wins
`default_nettype none
module pif_flag_reg #(
  parameter logic [7:0] IMPL  = 8'hff,
  parameter logic [7:0] SW_WR = 8'hff
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  // Software write port
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  // Hardware events
  input  wire logic [7:0] set_i,
  input  wire logic [7:0] hw_clr_i,
  // Flags
  output logic      [7:0] flags_o
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;

  always_comb
  begin
    flags_d = flags_q;
    if (wr_i)
    begin
      flags_d = (flags_q & ~SW_WR) | (wdata_i & SW_WR);
    end
    flags_d = flags_d & ~hw_clr_i;
    // Set applied last so an event is never lost to a clear
    flags_d = (flags_d | set_i) & IMPL;
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flags_q <= pif_pkg::RST_VALUE;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;
endmodule
`default_nettype wire

// *** tb/pif_event_src.sv ***
// Peripheral event source model: one-cycle set and clear pulses
`default_nettype none
module pif_event_src (
  // Clock
  input  wire logic       clock_i,
  // Event pulses toward the flag bank
  output var  logic [7:0] set1_o,
  output var  logic [7:0] set2_o,
  output var  logic [7:0] set3_o,
  output var  logic [7:0] set4_o,
  output var  logic [1:0] clr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    set1_o = 8'h00;
    set2_o = 8'h00;
    set3_o = 8'h00;
    set4_o = 8'h00;
    clr_o  = 2'h0;
  end

  // Events fire with no regard to enables or gates
  task automatic pulse(input int idx, input logic [7:0] bits, input logic [1:0] clr);
    @(posedge clock_i);
    set1_o <= (idx == 1) ? bits : 8'h00;
    set2_o <= (idx == 2) ? bits : 8'h00;
    set3_o <= (idx == 3) ? bits : 8'h00;
    set4_o <= (idx == 4) ? bits : 8'h00;
    clr_o  <= clr;
    @(posedge clock_i);
    // Event lines idle low, their real resting level
    set1_o <= 8'h00;
    set2_o <= 8'h00;
    set3_o <= 8'h00;
    set4_o <= 8'h00;
    clr_o  <= 2'h0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_pif_top.sv ***
// Self-checking bench for the peripheral interrupt flag bank
`default_nettype none
module tb_pif_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock;
  logic       arst_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rdata;
  logic [7:0] set1, set2, set3, set4;
  logic [1:0] clr;
  logic [7:0] en1, en2, en3;
  logic       gate_glob;
  logic       gate_per;
  logic       req;
  logic       wake;
  logic       irq;
  int         n_fail;
  int         checks;

  pif_event_src src (.clock_i(clock), .set1_o(set1), .set2_o(set2), .set3_o(set3),
                     .set4_o(set4), .clr_o(clr));

  pif_top dut (.clock_i(clock), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
               .wr_i(wr_en), .rd_i(rd_en), .rdata_o(rdata), .flags1_set_i(set1),
               .flags2_set_i(set2), .flags3_set_i(set3), .flags4_set_i(set4),
               .serial_flag_clr_i(clr), .enable1_i(en1), .enable2_i(en2), .enable3_i(en3),
               .global_irq_gate_i(gate_glob), .peripheral_irq_gate_i(gate_per),
               .periph_request_o(req), .wake_request_o(wake), .irq_o(irq));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, want, seen);
    end
  endtask

  // Strobes drop one edge later, so back-to-back calls never collide
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] want);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    chk(name, rdata, want);
  endtask

  // Request output is registered: allow flag, then request, to land
  task automatic settle();
    repeat (3) @(negedge clock);
  endtask

  task automatic test_reset_values();
    for (int i = 0; i < 7; i++)
      rd_chk("reset read", 4'(i), 8'h00);
    rd_chk("unmapped read", 4'hf, 8'h00);
    $display("test reset values done");
  endtask

  task automatic test_sw_access();
    logic [3:0] ofs [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
    logic [7:0] want [5] = '{8'h03, 8'hcf, 8'hf9, 8'h3a, 8'h00};
    for (int i = 0; i < 5; i++)
    begin
      bus_wr(ofs[i], 8'hff);
      rd_chk("write ones", ofs[i], want[i]);
    end
    rd_chk("read-only attempt status", 4'h5, 8'h02);
    for (int i = 0; i < 5; i++)
    begin
      bus_wr(ofs[i], 8'h00);
      rd_chk("write zeros", ofs[i], 8'h00);
    end
    bus_wr(4'h5, 8'h02);
    rd_chk("status cleared", 4'h5, 8'h00);
    $display("test software access done");
  endtask

  task automatic test_events();
    logic [7:0] want [4] = '{8'hff, 8'hf9, 8'h3a, 8'h03};
    for (int i = 0; i < 4; i++)
    begin
      src.pulse(i + 1, 8'hff, 2'h0);
      rd_chk("event set", 4'(i + 1), want[i]);
    end
    chk("request without enables", {7'h00, req}, 8'h00);
    src.pulse(0, 8'h00, 2'h3);
    rd_chk("serial unit clear", 4'h1, 8'hcf);
    for (int i = 0; i < 4; i++)
    begin
      bus_wr(4'(i + 1), 8'h00);
      rd_chk("software clear", 4'(i + 1), 8'h00);
    end
    $display("test events done");
  endtask

  task automatic test_request();
    // Stale flag cleared before its enable goes up
    bus_wr(4'h4, 8'h00);
    bus_wr(4'h0, 8'h01);
    bus_wr(4'h6, 8'h01);
    src.pulse(4, 8'h01, 2'h0);
    settle();
    chk("request gate off", {7'h00, req}, 8'h00);
    chk("wake gate off", {7'h00, wake}, 8'h00);
    @(posedge clock);
    gate_per <= 1'b1;
    settle();
    chk("wake gate on", {7'h00, wake}, 8'h01);
    chk("request global off", {7'h00, req}, 8'h00);
    @(posedge clock);
    gate_glob <= 1'b1;
    settle();
    chk("request all gates on", {7'h00, req}, 8'h01);
    chk("interrupt raised", {7'h00, irq}, 8'h01);
    bus_wr(4'h5, 8'h01);
    @(negedge clock);
    chk("interrupt cleared", {7'h00, irq}, 8'h00);
    bus_wr(4'h4, 8'h00);
    settle();
    chk("request after clear", {7'h00, req}, 8'h00);
    @(posedge clock);
    gate_glob <= 1'b0;
    gate_per  <= 1'b0;
    bus_wr(4'h0, 8'h00);
    bus_wr(4'h6, 8'h00);
    $display("test request gating done");
  endtask

  // Enables held outside the bank must gate flags 1 to 3 as well
  task automatic test_ext_enables();
    logic [7:0] bits [3] = '{8'h01, 8'h01, 8'h02};
    @(posedge clock);
    gate_per  <= 1'b1;
    gate_glob <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      // Enable a different bit first: flag alone must not request
      @(posedge clock);
      en1 <= (i == 0) ? 8'h02 : 8'h00;
      en2 <= (i == 1) ? 8'h08 : 8'h00;
      en3 <= (i == 2) ? 8'h08 : 8'h00;
      src.pulse(i + 1, bits[i], 2'h0);
      settle();
      chk("request other enable", {7'h00, req}, 8'h00);
      @(posedge clock);
      en1 <= (i == 0) ? bits[i] : 8'h00;
      en2 <= (i == 1) ? bits[i] : 8'h00;
      en3 <= (i == 2) ? bits[i] : 8'h00;
      settle();
      chk("request external enable", {7'h00, req}, 8'h01);
      bus_wr(4'(i + 1), 8'h00);
      settle();
      chk("request after flag clear", {7'h00, req}, 8'h00);
    end
    @(posedge clock);
    gate_per  <= 1'b0;
    gate_glob <= 1'b0;
    en1       <= 8'h00;
    en2       <= 8'h00;
    en3       <= 8'h00;
    $display("test external enables done");
  endtask

  task automatic test_mid_reset();
    src.pulse(3, 8'hff, 2'h0);
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd_chk("flags after reset", 4'h3, 8'h00);
    $display("test mid-run reset done");
  endtask

  initial
  begin
    n_fail    = 0;
    checks    = 0;
    arst_n    = 1'b0;
    addr      = 4'h0;
    wdata     = 8'h00;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    en1       = 8'h00;
    en2       = 8'h00;
    en3       = 8'h00;
    gate_glob = 1'b0;
    gate_per  = 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    test_reset_values();
    test_sw_access();
    test_events();
    test_request();
    test_ext_enables();
    test_mid_reset();
    print_verdict();
  end

  // Hang guard: running out counts against the run
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule
`default_nettype wire
